// [logic/anxnp_regs.vh]
// Purpose: Register offsets, field positions and reset values for the
//          auto-negotiation expansion / next page register bank.
// Assumes: 16-bit registers behind a plain strobe port.
// Notes:   Definitions only.
`ifndef ANXNP_REGS_VH
`define ANXNP_REGS_VH

// Register offsets
`define ANXNP_ADDR_W 5
`define ANXNP_OFS_EXP_STATUS 5'h06
`define ANXNP_OFS_NP_TX 5'h07
`define ANXNP_OFS_INT_STATUS 5'h18
`define ANXNP_OFS_INT_MASK 5'h19

// Expansion status fields
`define ANXNP_EXP_PDF 4
`define ANXNP_EXP_LPNP 3
`define ANXNP_EXP_LNP 2
`define ANXNP_EXP_PRX 1
`define ANXNP_EXP_LPAN 0
`define ANXNP_EXP_RSV_LO 5
`define ANXNP_EXP_RSV_HI 15
`define ANXNP_EXP_RSV_RST 11'h000

// Next page transmit fields
`define ANXNP_NP_MORE 15
`define ANXNP_NP_RSV 14
`define ANXNP_NP_FMT 13
`define ANXNP_NP_COMPLIANCE_ACK_BIT 12
`define ANXNP_NP_TGL 11
`define ANXNP_NP_CODE_HI 10
`define ANXNP_NP_CODE_LO 0
`define ANXNP_BASE_TGL_SRC 11

// Reset values
`define ANXNP_RST_MORE 1'b0
`define ANXNP_RST_FMT 1'b1
`define ANXNP_RST_COMPLIANCE_ACK_BIT 1'b0
`define ANXNP_RST_CODE 11'h001
`define ANXNP_RST_TGL 1'b0

// Interrupt status layout
`define ANXNP_INT_W 3
`define ANXNP_INT_PDF 0
`define ANXNP_INT_PRX 1
`define ANXNP_INT_NPSENT 2
`define ANXNP_INT_RST 3'h0

`define ANXNP_ZERO16 16'h0000

`endif

// [logic/anxnp_regs.v]
// Purpose: Expansion status and next page transmit registers with
//          latching flags, next page word assembly and an interrupt.
// Assumes: Engine event inputs are on mclk_i; override input is a pin.
// Notes:   Reads return data one cycle after the read strobe.
//
// Functional notes
// - Expansion reserved upper bits read zero.
// - Override-write bits writable only with override.
// - Parallel detection fault sets latched flag.
// - Partner next page bit sets status.
// - Local next page capable reads one.
// - New stored control word sets page received.
// - Expansion read clears page received flag.
// - Partner autoneg capable after valid bursts.
// - More-pages bit drives transmitted word.
// - Send next pages only when both able.
// - Next page reserved bit reads zero.
// - Page-format bit drives transmitted word.
// - Compliance-ack bit drives transmitted word.
// - Toggle inverts per sent next page.
// - Code field writable, resets to one.
// - Code field copied into transmitted word.
`timescale 1ns/100ps
`include "anxnp_regs.vh"

module anxnp_regs (
  // Clock and reset
  input wire mclk_i,
  input wire resetn_i,

  // Register port
  input wire [`ANXNP_ADDR_W-1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,

  // Override control pin, asynchronous
  input wire override_write_bits_i,

  // Auto-negotiation engine events
  input wire pd_fault_i,
  input wire page_stored_i,
  input wire [15:0] rx_word_i,
  input wire flp_valid_i,
  input wire [15:0] base_word_i,
  input wire base_sent_i,
  input wire np_sent_i,

  // Next page to transmit
  output wire [15:0] np_word_o,
  output wire np_enable_o,

  // Interrupt
  output wire irq_o
);

  localparam [`ANXNP_INT_W-1:0] INT_RST = `ANXNP_INT_RST;

  // Override synchroniser
  reg ovr_meta_ff;
  reg ovr_sync_ff;

  // Reserved expansion bits
  reg [`ANXNP_EXP_RSV_HI-`ANXNP_EXP_RSV_LO:0] rsv_ff;

  // Expansion status flags
  reg pdf_ff;
  reg prx_ff;
  reg lpnp_ff;
  reg lpan_ff;

  // Next page transmit fields
  reg more_ff;
  reg fmt_ff;
  reg compliance_ack_bit_ff;
  reg tgl_ff;
  reg [`ANXNP_NP_CODE_HI:0] code_ff;

  // Interrupt state
  reg [`ANXNP_INT_W-1:0] int_sts_ff;
  reg [`ANXNP_INT_W-1:0] int_msk_ff;

  // Read path
  reg [15:0] nxt_rdata;

  // Decodes
  wire wr_exp;
  wire wr_np;
  wire wr_int_sts;
  wire wr_int_msk;
  wire rd_exp;

  // Assembled words
  wire [15:0] exp_word;
  wire [15:0] np_reg_word;

  // Interrupt events
  wire [`ANXNP_INT_W-1:0] int_evt;

  assign wr_exp = wr_i && (addr_i == `ANXNP_OFS_EXP_STATUS);

  assign wr_np = wr_i && (addr_i == `ANXNP_OFS_NP_TX);

  assign wr_int_sts = wr_i && (addr_i == `ANXNP_OFS_INT_STATUS);

  assign wr_int_msk = wr_i && (addr_i == `ANXNP_OFS_INT_MASK);

  assign rd_exp = rd_i && (addr_i == `ANXNP_OFS_EXP_STATUS);

  // Override pin crosses in through two flops
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      ovr_meta_ff <= 1'b0;
      ovr_sync_ff <= 1'b0;
    end else begin
      ovr_meta_ff <= override_write_bits_i;
      ovr_sync_ff <= ovr_meta_ff;
    end
  end

  // Reserved bits store only under override but never read back
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      rsv_ff <= `ANXNP_EXP_RSV_RST;
    end else if (wr_exp && ovr_sync_ff) begin
      rsv_ff <= wdata_i[`ANXNP_EXP_RSV_HI:`ANXNP_EXP_RSV_LO];
    end
  end

  // Fault flag: set beats read-clear so no event is lost
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      pdf_ff <= 1'b0;
    end else if (pd_fault_i) begin
      pdf_ff <= 1'b1;
    end else if (rd_exp) begin
      pdf_ff <= 1'b0;
    end
  end

  // Page received flag, same set-wins order
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      prx_ff <= 1'b0;
    end else if (page_stored_i) begin
      prx_ff <= 1'b1;
    end else if (rd_exp) begin
      prx_ff <= 1'b0;
    end
  end

  // Partner next page ability follows each stored word
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      lpnp_ff <= 1'b0;
    end else if (page_stored_i) begin
      lpnp_ff <= rx_word_i[`ANXNP_NP_MORE];
    end
  end

  // Partner autoneg ability tracks burst validity
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      lpan_ff <= 1'b0;
    end else begin
      lpan_ff <= flp_valid_i;
    end
  end

  // Next page transmit register, more-pages field
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      more_ff <= `ANXNP_RST_MORE;
    end else if (wr_np) begin
      more_ff <= wdata_i[`ANXNP_NP_MORE];
    end
  end

  // Page-format field
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      fmt_ff <= `ANXNP_RST_FMT;
    end else if (wr_np) begin
      fmt_ff <= wdata_i[`ANXNP_NP_FMT];
    end
  end

  // Compliance-ack field
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      compliance_ack_bit_ff <= `ANXNP_RST_COMPLIANCE_ACK_BIT;
    end else if (wr_np) begin
      compliance_ack_bit_ff <= wdata_i[`ANXNP_NP_COMPLIANCE_ACK_BIT];
    end
  end

  // Code field
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      code_ff <= `ANXNP_RST_CODE;
    end else if (wr_np) begin
      code_ff <= wdata_i[`ANXNP_NP_CODE_HI:`ANXNP_NP_CODE_LO];
    end
  end

  // Toggle seeded from base word, flipped per next page sent
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      tgl_ff <= `ANXNP_RST_TGL;
    end else if (base_sent_i) begin
      tgl_ff <= ~base_word_i[`ANXNP_BASE_TGL_SRC];
    end else if (np_sent_i) begin
      tgl_ff <= ~tgl_ff;
    end
  end

  // Reserved field forced to zero on read
  assign exp_word = {{(`ANXNP_EXP_RSV_HI-`ANXNP_EXP_RSV_LO+1){1'b0}},
                     pdf_ff,
                     lpnp_ff,
                     1'b1,
                     prx_ff,
                     lpan_ff};

  assign np_reg_word = {more_ff,
                        1'b0,
                        fmt_ff,
                        compliance_ack_bit_ff,
                        tgl_ff,
                        code_ff};

  assign np_word_o = np_reg_word;

  // Next pages only when both ends are able
  assign np_enable_o = more_ff && lpnp_ff;

  // Interrupt events, one per status bit
  assign int_evt = {np_sent_i, page_stored_i, pd_fault_i};

  // Interrupt status, write one to clear, set wins
  genvar g;
  generate
    for (g = 0; g < `ANXNP_INT_W; g = g + 1) begin : g_int
      always @(posedge mclk_i) begin
        if (!resetn_i) begin
          int_sts_ff[g] <= INT_RST[g];
        end else if (int_evt[g]) begin
          int_sts_ff[g] <= 1'b1;
        end else if (wr_int_sts && wdata_i[g]) begin
          int_sts_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      int_msk_ff <= `ANXNP_INT_RST;
    end else if (wr_int_msk) begin
      int_msk_ff <= wdata_i[`ANXNP_INT_W-1:0];
    end
  end

  // Level interrupt; stays high until every unmasked bit is cleared
  assign irq_o = |(int_sts_ff & int_msk_ff);

  // Read decode; unmapped reads return zero
  always @* begin
    nxt_rdata = `ANXNP_ZERO16;
    if (!rd_i) begin
      nxt_rdata = `ANXNP_ZERO16;
    end else if (addr_i == `ANXNP_OFS_EXP_STATUS) begin
      nxt_rdata = exp_word;
    end else if (addr_i == `ANXNP_OFS_NP_TX) begin
      nxt_rdata = np_reg_word;
    end else if (addr_i == `ANXNP_OFS_INT_STATUS) begin
      nxt_rdata = {{(16-`ANXNP_INT_W){1'b0}}, int_sts_ff};
    end else if (addr_i == `ANXNP_OFS_INT_MASK) begin
      nxt_rdata = {{(16-`ANXNP_INT_W){1'b0}}, int_msk_ff};
    end
  end

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdata_o <= `ANXNP_ZERO16;
    end else begin
      rdata_o <= nxt_rdata;
    end
  end

endmodule // anxnp_regs

// [dv/anxnp_regs_assertions.sv]
// Purpose: port checks; Assumes: one clock; Notes: bound below
`timescale 1ns/100ps
module anxnp_chk (
  input wire logic mclk_i, resetn_i, rd_i, wr_i, pd_fault_i, page_stored_i,
  input wire logic flp_valid_i, base_sent_i, np_enable_o,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i, rdata_o, rx_word_i, base_word_i, np_word_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rd; rd_i && addr_i == 5'h06; endsequence
  sequence s_np; page_stored_i && rx_word_i[15]; endsequence
  AST_RSV: assert property (s_rd |=> !rdata_o[15:5]) else $error("rsv");
  AST_PDF: assert property (pd_fault_i ##1 s_rd |=> rdata_o[4]) else $error("pdf");
  AST_LPNP: assert property (s_np ##1 s_rd |=> rdata_o[3]) else $error("lpnp");
  AST_PRX: assert property ((s_rd and !page_stored_i) ##1 !page_stored_i ##1 s_rd |=>
    !rdata_o[1]) else $error("prx");
  AST_LPAN: assert property (!flp_valid_i ##1 s_rd |=> !rdata_o[0])
    else $error("lpan");
  AST_NPW: assert property (wr_i && addr_i == 5'h07 |=>
    (np_word_o & 16'hF7FF) == ($past(wdata_i) & 16'hB7FF)) else $error("npw");
  AST_TGL: assert property (base_sent_i |=> np_word_o[11] != $past(base_word_i[11]))
    else $error("tgl");
  AST_NPEN: assert property (!np_word_o[15] |-> !np_enable_o) else $error("npen");
endmodule // anxnp_chk
bind anxnp_regs anxnp_chk i_chk (.*);

// [dv/anxnp_sta.sv]
// Purpose: management master; Assumes: strobe bus; Notes: tasks
`timescale 1ns/100ps
module anxnp_sta (
  input wire logic mclk_i,
  input wire logic [15:0] rdata_i,
  output logic [4:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk_i) addr_o <= a;
    wdata_o <= (a == 5'h06) ? v & 16'h001F : (a == 5'h07) ? v & 16'hBFFF : v;
    wr_o <= 1'h1;
    @(posedge mclk_i) wr_o <= 1'h0;
    wdata_o <= ~wdata_o;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge mclk_i) addr_o <= a;
    rd_o <= 1'h1;
    @(posedge mclk_i) rd_o <= 1'h0;
    #1 v = rdata_i;
  endtask
endmodule // anxnp_sta

// [dv/anxnp_regs_tb.sv]
// Purpose: bench; Assumes: 200 MHz; Notes: fixed stimulus
`timescale 1ns/100ps
module anxnp_regs_tb;
  logic mclk_i = '0, resetn_i = '0, override_write_bits_i = '0, pd_fault_i = '0;
  logic page_stored_i = '0, flp_valid_i = '0, base_sent_i = '0, np_sent_i = '0;
  logic [15:0] rx_word_i = '0, base_word_i = '0, d;
  wire [4:0] addr_i;
  wire [15:0] wdata_i, rdata_o, np_word_o;
  wire wr_i, rd_i, np_enable_o, irq_o;
  int err_total = 0, checked = 0;
  logic [15:0] w [4] = '{16'h8000, 16'h2001, 16'h1FFF, 16'hA955};
  logic [15:0] e [4] = '{16'h8000, 16'h2001, 16'h17FF, 16'hA155};
  anxnp_regs i_dut (.*);
  anxnp_sta i_sta (.mclk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i));
  initial forever #2.5 mclk_i = ~mclk_i;
  initial begin
    #50000;
    err_total++;
    finish_test;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic stor(input logic [15:0] r);
    @(posedge mclk_i) {page_stored_i, rx_word_i} <= {1'h1, r};
    @(posedge mclk_i) page_stored_i <= 1'h0;
    #1;
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'h1;
    i_sta.rd(5'h06, d);
    chk(d, 16'h0004);
    i_sta.rd(5'h07, d);
    chk(d, 16'h2001);
    foreach (w[i]) begin
      i_sta.wr(5'h07, w[i]);
      chk(np_word_o, e[i]);
      i_sta.rd(5'h07, d);
      chk(d, e[i]);
    end
    @(posedge mclk_i) base_sent_i <= 1'h1;
    @(posedge mclk_i) base_sent_i <= 1'h0;
    #1 chk(np_word_o, 16'hA955);
    @(posedge mclk_i) np_sent_i <= 1'h1;
    @(posedge mclk_i) np_sent_i <= 1'h0;
    #1 chk(np_word_o, 16'hA155);
    stor(16'h8000);
    chk({15'h0000, np_enable_o}, 16'h0001);
    stor(16'h0000);
    chk({15'h0000, np_enable_o}, 16'h0000);
    @(posedge mclk_i) {pd_fault_i, page_stored_i, flp_valid_i, rx_word_i} <= {3'h7, 16'h8000};
    fork
      i_sta.rd(5'h06, d);
      @(posedge mclk_i) {pd_fault_i, page_stored_i} <= 2'h0;
    join
    chk(d, 16'h001F);
    i_sta.rd(5'h06, d);
    chk(d, 16'h000D);
    @(posedge mclk_i) flp_valid_i <= 1'h0;
    i_sta.rd(5'h06, d);
    chk(d, 16'h000C);
    i_sta.rd(5'h18, d);
    chk(d, 16'h0007);
    chk({15'h0000, irq_o}, 16'h0000);
    i_sta.wr(5'h19, 16'h0004);
    chk({15'h0000, irq_o}, 16'h0001);
    i_sta.wr(5'h18, 16'h0004);
    chk({15'h0000, irq_o}, 16'h0000);
    i_sta.rd(5'h1F, d);
    chk(d, 16'h0000);
    finish_test;
  end
endmodule // anxnp_regs_tb
